// ---- lpsbi_top.sv ----
// top: low power sdram command, mask and address ball interface
// Summary of operation
// - all inputs captured on rising clock
// - clock advances burst counter, output registers
// - clock enable low picks a power state
// - clock enable asynchronous while powered down; here the raw level is sampled on rising clock
// - input buffers off in power down, self refresh
// - chip select high ignores the command
// - select and three strobes form command
// - write mask high blocks byte storage
// - read mask high floats byte two later; here the output enable drops three cycles later
// - x16: low mask low byte, high upper
// - x32: four masks govern bytes in order
// - bank select picks the addressed bank
// - bank select ignored on all-bank precharge
// - address carries row, column, auto precharge
// - bit ten chooses all or one bank
// - address gives mode register op-code
// - collective mask means all masks equal
module lpsbi_top
   import lpsbi_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic clkEnable,
   input wire logic chipSelN,
   input wire logic rowStrobeN,
   input wire logic colStrobeN,
   input wire logic writeStrobeN,
   input wire logic bank_sel0,
   input wire logic bank_sel1,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic wide32,
   input wire logic low_byte_mask,
   input wire logic high_byte_mask,
   input wire logic [LANES-1:0] laneMask,
   input wire logic [DATA_W-1:0] dqIn,
   input wire logic [DATA_W-1:0] rdData,
   input wire logic selfRefReq,
   input wire logic deepPdReq,
   output logic [DATA_W-1:0] dqOut,
   output logic [DATA_W-1:0] dqOe,
   output logic [DATA_W-1:0] wrData_q,
   output logic [LANES-1:0] wrByteEn_q,
   output logic wrStrobe_q,
   output logic [1:0] accBank_q,
   output logic [COL_W-1:0] accCol_q,
   output logic [ROW_W-1:0] actRow_q,
   output logic [BANKS-1:0] bankOpen_q,
   output logic autoPre_q,
   output logic [MODE_W-1:0] modeReg_q,
   output logic bufOn_q,
   output lpsbi_pwr_t pwrState_q
);
   logic clkOn;
   logic [LANES-1:0] maskNow;
   logic [LANES-1:0] maskRd;
   logic burst_q;
   logic rdActive_q;
   lpsbi_cmd_if cmdBus();

   assign clkOn = pwrState_q == LPSBI_RUN;

   // lane masks: x16 maps low/high to lanes 0/1, upper lanes unused
   always_comb begin
      if (wide32) begin
         maskNow = laneMask;
      end else begin
         maskNow = {2'h0, high_byte_mask, low_byte_mask};
      end
   end

   lpsbi_cmd_dec uDec (
      .clk(clk),
      .rstn(rstn),
      .clkOn(clkOn),
      .csN(chipSelN),
      .rasN(rowStrobeN),
      .casN(colStrobeN),
      .weN(writeStrobeN),
      .bankSel({bank_sel1, bank_sel0}),
      .addr(addr),
      .out(cmdBus.dec)
   );

   lpsbi_mask_pipe uMask (
      .clk(clk),
      .rstn(rstn),
      .maskIn(maskNow),
      .maskOut(maskRd)
   );

   // power state selection when clock enable drops
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pwrState_q <= LPSBI_RUN;
      end else begin
         case (pwrState_q)
            LPSBI_RUN: begin
               if (!clkEnable) begin
                  if (rdActive_q || burst_q) begin
                     pwrState_q <= LPSBI_SUSP;
                  end else if (bankOpen_q != '0) begin
                     pwrState_q <= LPSBI_APD;
                  end else if (deepPdReq) begin
                     pwrState_q <= LPSBI_DPD;
                  end else if (selfRefReq) begin
                     pwrState_q <= LPSBI_SREF;
                  end else begin
                     pwrState_q <= LPSBI_PPD;
                  end
               end
            end
            // exit on raw level: the clock enable is not qualified here
            LPSBI_PPD, LPSBI_APD, LPSBI_SREF, LPSBI_DPD: begin
               if (clkEnable) begin
                  pwrState_q <= LPSBI_RUN;
               end
            end
            LPSBI_SUSP: begin
               if (clkEnable) begin
                  pwrState_q <= LPSBI_RUN;
               end
            end
            default: pwrState_q <= LPSBI_RUN;
         endcase
      end
   end

   // input buffer enable off while powered down or refreshing itself
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bufOn_q <= 1'b1;
      end else begin
         bufOn_q <= !(pwrState_q inside {LPSBI_PPD, LPSBI_APD, LPSBI_SREF, LPSBI_DPD});
      end
   end

   // bank open tracking
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bankOpen_q <= '0;
      end else if (cmdBus.valid) begin
         if (cmdBus.cmd == LPSBI_ACT) begin
            bankOpen_q[cmdBus.bank] <= 1'b1;
         end else if (cmdBus.cmd == LPSBI_PRE) begin
            if (cmdBus.allBanks) begin
               bankOpen_q <= '0;
            end else begin
               bankOpen_q[cmdBus.bank] <= 1'b0;
            end
         end
      end
   end

   // row, bank, auto precharge capture; only the used address bits are read
   always_ff @(posedge clk) begin
      if (!rstn) begin
         actRow_q <= ROW_RST;
         accBank_q <= 2'h0;
         autoPre_q <= 1'b0;
      end else if (cmdBus.valid) begin
         if (cmdBus.cmd == LPSBI_ACT) begin
            // x32 row is 12 bits; top row bit is reserved there
            actRow_q <= wide32 ? {1'b0, cmdBus.addr[ROW_W-2:0]} : cmdBus.addr[ROW_W-1:0];
            accBank_q <= cmdBus.bank;
         end else if (cmdBus.cmd == LPSBI_RD || cmdBus.cmd == LPSBI_WR) begin
            autoPre_q <= cmdBus.addr[PRE_SEL_POS];
            accBank_q <= cmdBus.bank;
         end
      end
   end

   // burst column counter advances on every running clock while a burst is active, except one taking a read, write, burst stop or precharge
   always_ff @(posedge clk) begin
      if (!rstn) begin
         accCol_q <= COL_RST;
         burst_q <= 1'b0;
         rdActive_q <= 1'b0;
      end else if (cmdBus.valid && (cmdBus.cmd == LPSBI_RD || cmdBus.cmd == LPSBI_WR)) begin
         accCol_q <= cmdBus.addr[COL_W-1:0];
         burst_q <= 1'b1;
         rdActive_q <= cmdBus.cmd == LPSBI_RD;
      end else if (cmdBus.valid && (cmdBus.cmd == LPSBI_BST || cmdBus.cmd == LPSBI_PRE)) begin
         burst_q <= 1'b0;
         rdActive_q <= 1'b0;
      end else if (clkOn && burst_q) begin
         accCol_q <= accCol_q + 9'h001;
      end
   end

   // mode register load
   always_ff @(posedge clk) begin
      if (!rstn) begin
         modeReg_q <= MODE_RST;
      end else if (cmdBus.valid && cmdBus.cmd == LPSBI_LMR) begin
         modeReg_q <= cmdBus.addr[MODE_W-1:0];
      end
   end

   // write data capture with byte enables
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wrData_q <= '0;
         wrByteEn_q <= '0;
         wrStrobe_q <= 1'b0;
      end else begin
         wrData_q <= dqIn;
         wrByteEn_q <= ~maskNow & (wide32 ? 4'hF : 4'h3);
         wrStrobe_q <= clkOn && burst_q && !rdActive_q;
      end
   end

   // read output registers, per lane enable three cycles after the mask
   genvar l;
   generate
      for (l = 0; l < LANES; l++) begin : gLane
         always_ff @(posedge clk) begin
            if (!rstn) begin
               dqOut[8*l +: 8] <= 8'h00;
               dqOe[8*l +: 8] <= 8'h00;
            end else begin
               dqOut[8*l +: 8] <= rdData[8*l +: 8];
               // the flop adds a cycle on top of the two-stage mask maskRd
               dqOe[8*l +: 8] <= {8{rdActive_q && clkOn && !maskRd[l]
                  && (wide32 || l < 2)}};
            end
         end
      end
   endgenerate

   a_pre_one: assert property (@(posedge clk) disable iff (!rstn)
      (cmdBus.valid && cmdBus.cmd == LPSBI_PRE && !cmdBus.allBanks)
      |=> bankOpen_q[$past(cmdBus.bank)] == 1'b0) else $error("single precharge missed");
   a_pre_all_clr: assert property (@(posedge clk) disable iff (!rstn)
      (cmdBus.valid && cmdBus.cmd == LPSBI_PRE && cmdBus.allBanks)
      |=> bankOpen_q == '0) else $error("all bank precharge missed");
   a_mode_load: assert property (@(posedge clk) disable iff (!rstn)
      (cmdBus.valid && cmdBus.cmd == LPSBI_LMR) |=> modeReg_q == $past(cmdBus.addr[MODE_W-1:0]))
      else $error("mode op-code not loaded");
   a_wr_mask: assert property (@(posedge clk) disable iff (!rstn)
      (wide32 && laneMask[2]) |=> !wrByteEn_q[2]) else $error("masked byte enabled");
   a_pd_buf: assert property (@(posedge clk) disable iff (!rstn)
      (pwrState_q == LPSBI_SREF) |=> !bufOn_q) else $error("buffers on in self refresh");
   a_apd_entry: assert property (@(posedge clk) disable iff (!rstn)
      (clkOn && !clkEnable && bankOpen_q != '0 && !burst_q && !rdActive_q)
      |=> pwrState_q == LPSBI_APD) else $error("active power-down not entered");
   a_col_inc: assert property (@(posedge clk) disable iff (!rstn)
      (clkOn && burst_q && !cmdBus.valid) |=> accCol_q == $past(accCol_q) + 9'h001)
      else $error("burst counter stalled");
   a_x16_hi_lane: assert property (@(posedge clk) disable iff (!rstn)
      !wide32 |=> dqOe[31:16] == '0) else $error("unused lanes driven in x16");
   a_ppd_entry: assert property (@(posedge clk) disable iff (!rstn)
      (clkOn && !clkEnable && !burst_q && !rdActive_q && bankOpen_q == '0 && !deepPdReq
      && !selfRefReq) |=> pwrState_q == LPSBI_PPD) else $error("precharge power-down missed");
   a_sref_entry: assert property (@(posedge clk) disable iff (!rstn)
      (clkOn && !clkEnable && !burst_q && !rdActive_q && bankOpen_q == '0 && !deepPdReq
      && selfRefReq) |=> pwrState_q == LPSBI_SREF) else $error("self refresh missed");
   a_dpd_entry: assert property (@(posedge clk) disable iff (!rstn)
      (clkOn && !clkEnable && !burst_q && !rdActive_q && bankOpen_q == '0 && deepPdReq)
      |=> pwrState_q == LPSBI_DPD) else $error("deep power-down missed");
   a_susp_entry: assert property (@(posedge clk) disable iff (!rstn)
      (clkOn && !clkEnable && (burst_q || rdActive_q)) |=> pwrState_q == LPSBI_SUSP)
      else $error("clock suspend missed");
   a_off_ignore: assert property (@(posedge clk) disable iff (!rstn)
      !clkOn |=> !cmdBus.valid) else $error("command taken with clock off");
   a_pd_exit: assert property (@(posedge clk) disable iff (!rstn)
      (pwrState_q inside {LPSBI_PPD, LPSBI_APD, LPSBI_SREF, LPSBI_DPD} && clkEnable)
      |=> pwrState_q == LPSBI_RUN) else $error("power-down exit missed");
   a_pd_buf_all: assert property (@(posedge clk) disable iff (!rstn)
      (pwrState_q inside {LPSBI_PPD, LPSBI_APD, LPSBI_DPD}) |=> !bufOn_q)
      else $error("buffers on in power-down");
   a_act_row: assert property (@(posedge clk) disable iff (!rstn)
      (cmdBus.valid && cmdBus.cmd == LPSBI_ACT && !wide32)
      |=> actRow_q == $past(cmdBus.addr[ROW_W-1:0])) else $error("row not captured");
   a_act_bank: assert property (@(posedge clk) disable iff (!rstn)
      (cmdBus.valid && cmdBus.cmd == LPSBI_ACT) |=> bankOpen_q[$past(cmdBus.bank)])
      else $error("activated bank not open");
   a_auto_pre: assert property (@(posedge clk) disable iff (!rstn)
      (cmdBus.valid && (cmdBus.cmd == LPSBI_RD || cmdBus.cmd == LPSBI_WR))
      |=> autoPre_q == $past(cmdBus.addr[PRE_SEL_POS])) else $error("auto precharge wrong");
   a_col_load: assert property (@(posedge clk) disable iff (!rstn)
      (cmdBus.valid && (cmdBus.cmd == LPSBI_RD || cmdBus.cmd == LPSBI_WR))
      |=> accCol_q == $past(cmdBus.addr[COL_W-1:0])) else $error("column not captured");
   a_wr_mask_x16: assert property (@(posedge clk) disable iff (!rstn)
      (!wide32 && low_byte_mask) |=> !wrByteEn_q[0]) else $error("low byte not masked");
   a_rd_float: assert property (@(posedge clk) disable iff (!rstn)
      maskRd[1] |=> dqOe[15:8] == 8'h00) else $error("masked read byte driven");
   a_out_reg: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> dqOut == $past(rdData)) else $error("read data not registered");
   a_wr_data: assert property (@(posedge clk) disable iff (!rstn)
      1'b1 |=> wrData_q == $past(dqIn)) else $error("write data not captured");
   c_act: cover property (@(posedge clk) cmdBus.valid && cmdBus.cmd == LPSBI_ACT);
   c_rd_masked: cover property (@(posedge clk) rdActive_q && maskRd != '0);
   c_sref: cover property (@(posedge clk) pwrState_q == LPSBI_SREF);
   c_susp: cover property (@(posedge clk) pwrState_q == LPSBI_SUSP);
endmodule

// ---- lpsbi_pkg.sv ----
// package: constants and types for the sdram ball interface
package lpsbi_pkg;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int ADDR_W = 14;
   localparam int BANKS = 4;
   localparam int ROW_W = 13;
   localparam int COL_W = 9;
   localparam int PRE_SEL_POS = 10;
   localparam int MASK_LAT = 2;
   localparam int MODE_W = 13;
   localparam logic [MODE_W-1:0] MODE_RST = 13'h0000;
   localparam logic [COL_W-1:0] COL_RST = 9'h000;
   localparam logic [ROW_W-1:0] ROW_RST = 13'h0000;
   // command code {cs, ras, cas, we}, active low strobes
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_LMR = 4'h0;
   localparam logic [3:0] CMD_BST = 4'h6;
   typedef enum logic [2:0] {
      LPSBI_NONE, LPSBI_ACT, LPSBI_RD, LPSBI_WR, LPSBI_PRE, LPSBI_REF, LPSBI_LMR, LPSBI_BST
   } lpsbi_cmd_t;
   typedef enum {
      LPSBI_RUN, LPSBI_PPD, LPSBI_APD, LPSBI_SREF, LPSBI_DPD, LPSBI_SUSP
   } lpsbi_pwr_t;
endpackage

// ---- lpsbi_cmd_if.sv ----
// interface: decoded command from decoder to core
interface lpsbi_cmd_if;
   import lpsbi_pkg::*;
   logic valid;
   lpsbi_cmd_t cmd;
   logic [1:0] bank;
   logic [ADDR_W-1:0] addr;
   logic allBanks;
   modport dec (output valid, cmd, bank, addr, allBanks);
   modport core (input valid, cmd, bank, addr, allBanks);
endinterface

// ---- lpsbi_cmd_dec.sv ----
// command decoder over raw chip select and strobes, decoded result registered
module lpsbi_cmd_dec
   import lpsbi_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic clkOn,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic [1:0] bankSel,
   input wire logic [ADDR_W-1:0] addr,
   lpsbi_cmd_if.dec out
);
   logic [3:0] code;
   lpsbi_cmd_t cmdD;
   assign code = {csN, rasN, casN, weN};
   always_comb begin
      case (code)
         CMD_ACT: cmdD = LPSBI_ACT;
         CMD_RD: cmdD = LPSBI_RD;
         CMD_WR: cmdD = LPSBI_WR;
         CMD_PRE: cmdD = LPSBI_PRE;
         CMD_REF: cmdD = LPSBI_REF;
         CMD_LMR: cmdD = LPSBI_LMR;
         CMD_BST: cmdD = LPSBI_BST;
         default: cmdD = LPSBI_NONE;
      endcase
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         out.valid <= 1'b0;
         out.cmd <= LPSBI_NONE;
         out.bank <= 2'h0;
         out.addr <= '0;
         out.allBanks <= 1'b0;
      end else begin
         // gated clock: nothing is taken while the internal clock is off
         out.valid <= clkOn && !csN && cmdD != LPSBI_NONE;
         out.cmd <= cmdD;
         out.bank <= bankSel;
         out.addr <= addr;
         out.allBanks <= cmdD == LPSBI_PRE && addr[PRE_SEL_POS];
      end
   end
   a_cs_masks: assert property (@(posedge clk) disable iff (!rstn)
      csN |=> !out.valid) else $error("command taken with chip select high");
   a_pre_all: assert property (@(posedge clk) disable iff (!rstn)
      (clkOn && code == CMD_PRE && addr[PRE_SEL_POS]) |=> (out.valid && out.allBanks))
      else $error("all bank precharge not flagged");
endmodule

// ---- lpsbi_mask_pipe.sv ----
// byte mask pipeline for read output enable
module lpsbi_mask_pipe
   import lpsbi_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [LANES-1:0] maskIn,
   output logic [LANES-1:0] maskOut
);
   logic [LANES-1:0] stage_q [MASK_LAT];
   genvar g;
   generate
      for (g = 0; g < MASK_LAT; g++) begin : gStage
         // split so the first stage never names an index below zero
         if (g == 0) begin : gFirst
            always_ff @(posedge clk) begin
               if (!rstn) begin
                  stage_q[g] <= '0;
               end else begin
                  stage_q[g] <= maskIn;
               end
            end
         end else begin : gNext
            always_ff @(posedge clk) begin
               if (!rstn) begin
                  stage_q[g] <= '0;
               end else begin
                  stage_q[g] <= stage_q[g-1];
               end
            end
         end
      end
   endgenerate
   assign maskOut = stage_q[MASK_LAT-1];
   a_mask_lat: assert property (@(posedge clk) disable iff (!rstn)
      ##2 maskOut == $past(maskIn, 2)) else $error("read mask latency not two");
endmodule

// ---- lpsbi_ctrl_model.sv ----
// partner: memory controller driving command, address and mask balls
module lpsbi_ctrl_model
   import lpsbi_pkg::*;
(
   input wire logic clk,
   output logic clkEnable,
   output logic chipSelN,
   output logic rowStrobeN,
   output logic colStrobeN,
   output logic writeStrobeN,
   output logic bank_sel0,
   output logic bank_sel1,
   output logic [ADDR_W-1:0] addr,
   output logic low_byte_mask,
   output logic high_byte_mask,
   output logic [LANES-1:0] laneMask,
   output logic [DATA_W-1:0] dqIn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      clkEnable = 1'b1;
      {chipSelN, rowStrobeN, colStrobeN, writeStrobeN} = CMD_NOP;
      {bank_sel1, bank_sel0} = 2'h0;
      addr = 14'h0000;
      {low_byte_mask, high_byte_mask, laneMask} = 6'h00;
      dqIn = 32'h00000000;
   end
   // select, strobes and operands move together, held one edge
   task automatic cmd(input logic [3:0] code, input logic [1:0] bank,
                      input logic [ADDR_W-1:0] a);
      @(posedge clk);
      {chipSelN, rowStrobeN, colStrobeN, writeStrobeN} <= code;
      {bank_sel1, bank_sel0} <= bank;
      addr <= a;
      @(posedge clk);
      {chipSelN, rowStrobeN, colStrobeN, writeStrobeN} <= CMD_NOP;
      // stale operands inverted so a late sample cannot pass
      addr <= ~a;
      {bank_sel1, bank_sel0} <= ~bank;
   endtask
   task automatic mask(input logic [LANES-1:0] m, input logic [DATA_W-1:0] d);
      @(posedge clk);
      low_byte_mask <= m[0];
      high_byte_mask <= m[1];
      laneMask <= m;
      dqIn <= d;
   endtask
   // exit taken synchronously here; async exit is not modelled
   task automatic cke(input logic v);
      @(posedge clk);
      clkEnable <= v;
   endtask
endmodule

// ---- test_lp_sdram_ball_interface.sv ----
// bench: command, mask and power checks of the sdram ball interface
module test_lp_sdram_ball_interface import lpsbi_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rstn, wide32, selfRefReq, deepPdReq;
   logic clkEnable, chipSelN, rowStrobeN, colStrobeN, writeStrobeN;
   logic bank_sel0, bank_sel1, low_byte_mask, high_byte_mask, wrStrobe_q;
   logic autoPre_q, bufOn_q;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0] laneMask, wrByteEn_q;
   logic [DATA_W-1:0] dqIn, rdData, dqOut, dqOe, wrData_q;
   logic [1:0] accBank_q;
   logic [COL_W-1:0] accCol_q;
   logic [ROW_W-1:0] actRow_q;
   logic [BANKS-1:0] bankOpen_q;
   logic [MODE_W-1:0] modeReg_q;
   lpsbi_pwr_t pwrState_q;
   int miscompares = 0;
   int n_checks = 0;
   lpsbi_ctrl_model lpsbi_ctrl_model_inst (.clk, .clkEnable, .chipSelN,
      .rowStrobeN, .colStrobeN, .writeStrobeN, .bank_sel0, .bank_sel1, .addr,
      .low_byte_mask, .high_byte_mask, .laneMask, .dqIn);
   lpsbi_top lpsbi_top_inst (.clk, .rstn, .clkEnable, .chipSelN, .rowStrobeN,
      .colStrobeN, .writeStrobeN, .bank_sel0, .bank_sel1, .addr, .wide32,
      .low_byte_mask, .high_byte_mask, .laneMask, .dqIn, .rdData, .selfRefReq,
      .deepPdReq, .dqOut, .dqOe, .wrData_q, .wrByteEn_q, .wrStrobe_q, .accBank_q,
      .accCol_q, .actRow_q, .bankOpen_q, .autoPre_q, .modeReg_q, .bufOn_q,
      .pwrState_q);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic t_act();
      lpsbi_ctrl_model_inst.cmd(CMD_ACT, 2'h1, 14'h1ABC);
      tick(1);
      chk(bankOpen_q, 4'h2);
      chk(actRow_q, 13'h1ABC);
      // same code with select high must leave no trace
      lpsbi_ctrl_model_inst.cmd(4'hB, 2'h2, 14'h0055);
      tick(2);
      chk(bankOpen_q, 4'h2);
      chk(actRow_q, 13'h1ABC);
      lpsbi_ctrl_model_inst.cmd(CMD_LMR, 2'h0, 14'h0A33);
      tick(1);
      chk(modeReg_q, 13'h0A33);
   endtask
   task automatic t_wmask();
      logic [3:0] mk [4] = '{4'h1, 4'h2, 4'h9, 4'h6};
      logic [3:0] en [4] = '{4'h2, 4'h1, 4'h6, 4'h9};
      for (int i = 0; i < 4; i++) begin
         lpsbi_ctrl_model_inst.mask(mk[i], {8{mk[i]}});
         wide32 <= (i > 1);
         tick(1);
         chk(wrByteEn_q, en[i]);
         chk(wrData_q, {8{mk[i]}});
      end
   endtask
   task automatic t_read();
      lpsbi_ctrl_model_inst.mask(4'h0, 32'h00000000);
      lpsbi_ctrl_model_inst.cmd(CMD_RD, 2'h1, 14'h05F0);
      tick(1);
      chk(accCol_q, 9'h1F0);
      chk(autoPre_q, 1'b1);
      chk(accBank_q, 2'h1);
      tick(1);
      chk(accCol_q, 9'h1F1);
      chk(dqOut, 32'h5A5AA5A5);
      lpsbi_ctrl_model_inst.mask(4'h4, 32'h00000000);
      tick(2);
      chk(dqOe, 32'hFFFFFFFF);
      tick(1);
      chk(dqOe, 32'hFF00FFFF);
      lpsbi_ctrl_model_inst.mask(4'h0, 32'h00000000);
   endtask
   task automatic t_pre();
      lpsbi_ctrl_model_inst.cmd(CMD_PRE, 2'h1, 14'h0400);
      tick(1);
      chk(bankOpen_q, 4'h0);
      lpsbi_ctrl_model_inst.cmd(CMD_ACT, 2'h0, 14'h0011);
      lpsbi_ctrl_model_inst.cmd(CMD_ACT, 2'h3, 14'h0022);
      lpsbi_ctrl_model_inst.cmd(CMD_WR, 2'h0, 14'h0007);
      tick(1);
      chk(accCol_q, 9'h007);
      tick(1);
      chk(wrStrobe_q, 1'b1);
      lpsbi_ctrl_model_inst.cmd(CMD_BST, 2'h0, 14'h0000);
      lpsbi_ctrl_model_inst.cmd(CMD_REF, 2'h0, 14'h0000);
      lpsbi_ctrl_model_inst.cmd(CMD_PRE, 2'h3, 14'h0000);
      tick(1);
      chk(bankOpen_q, 4'h1);
   endtask
   task automatic t_pwr(input lpsbi_pwr_t exp, input logic sr, input logic dp);
      @(posedge clk);
      selfRefReq <= sr;
      deepPdReq <= dp;
      lpsbi_ctrl_model_inst.cke(1'b0);
      for (int i = 0; i < 8 && pwrState_q !== exp; i++) tick(1);
      chk(pwrState_q, exp);
      tick(1);
      chk(bufOn_q, 1'b0);
      lpsbi_ctrl_model_inst.cke(1'b1);
      tick(3);
      chk(pwrState_q, LPSBI_RUN);
      chk(bufOn_q, 1'b1);
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      rstn = 1'b0;
      wide32 = 1'b0;
      selfRefReq = 1'b0;
      deepPdReq = 1'b0;
      rdData = 32'h5A5AA5A5;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      tick(1);
      chk(bufOn_q, 1'b1);
      chk(pwrState_q, LPSBI_RUN);
      chk(bankOpen_q, 4'h0);
      t_act();
      t_wmask();
      t_read();
      t_pre();
      t_pwr(LPSBI_APD, 1'b0, 1'b0);
      lpsbi_ctrl_model_inst.cmd(CMD_PRE, 2'h0, 14'h0400);
      t_pwr(LPSBI_PPD, 1'b0, 1'b0);
      t_pwr(LPSBI_SREF, 1'b1, 1'b0);
      t_pwr(LPSBI_DPD, 1'b0, 1'b1);
      conclude();
   end
   // run needs about a hundred cycles; this is far beyond
   initial begin
      #20000;
      miscompares++;
      conclude();
   end
endmodule
